// >>> rtl/ptpclk_regs.svh
// register offsets, field positions and reset values of the time clock unit
`ifndef PTPCLK_REGS_SVH
`define PTPCLK_REGS_SVH
`define PTPCLK_P1_UUID_OFS   12'h11c
`define PTPCLK_P2_UUID_OFS   12'h13c
`define PTPCLK_P0_UUID_OFS   12'h15c
`define PTPCLK_G8_HI_OFS     12'h160
`define PTPCLK_G8_LO_OFS     12'h164
`define PTPCLK_G9_HI_OFS     12'h168
`define PTPCLK_G9_LO_OFS     12'h16c
`define PTPCLK_CNT_HI_OFS    12'h170
`define PTPCLK_CNT_LO_OFS    12'h174
`define PTPCLK_TRIM_OFS      12'h178
`define PTPCLK_GOAL_HI_OFS   12'h17c
`define PTPCLK_GOAL_LO_OFS   12'h180
`define PTPCLK_CMD_OFS       12'h1a0
`define PTPCLK_CFG_OFS       12'h1a4
`define PTPCLK_STAT_OFS      12'h1a8
`define PTPCLK_CMD_FREEZE_BIT 0
`define PTPCLK_CFG_MS0_BIT   0
`define PTPCLK_CFG_MS1_BIT   1
`define PTPCLK_CFG_MS2_BIT   2
`define PTPCLK_CFG_IE_BIT    3
`define PTPCLK_STAT_HIT_BIT  0
`define PTPCLK_ZERO32        32'h0000_0000
`define PTPCLK_ZERO64        64'h0000_0000_0000_0000
`define PTPCLK_ONE64         64'h0000_0000_0000_0001
`define PTPCLK_ADDR_W        12
`define PTPCLK_NPORT         3
`endif

// >>> rtl/ptpclk_pkg.sv
// types shared by the time clock unit
`default_nettype none
package ptpclk_pkg;
  typedef logic [63:0] ptpclk_time_t;
  typedef logic [31:0] ptpclk_word_t;
  typedef enum logic [1:0] {
    PTPCLK_HALF_NONE  = 2'b00,
    PTPCLK_HALF_UPPER = 2'b01,
    PTPCLK_HALF_LOWER = 2'b10
  } ptpclk_half_e;
endpackage
`default_nettype wire

// >>> rtl/ptpclk_top.sv
// precision time clock with pin, packet and compare capture
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ptpclk_regs.svh"
module ptpclk_top
  import ptpclk_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pin8_in,
  input  wire logic        pin9_in,
  input  wire logic [2:0]  tx_sync_seen,
  input  wire logic [2:0]  tx_dreq_seen,
  input  wire logic [95:0] tx_origin_id,
  output logic             goal_hit_irq
);

  // bus decode
  wire logic wr_acc = psel & penable & pwrite;
  wire logic rd_acc = psel & penable & ~pwrite;
  wire logic wr_cnt_hi  = wr_acc && (paddr == `PTPCLK_CNT_HI_OFS);
  wire logic wr_cnt_lo  = wr_acc && (paddr == `PTPCLK_CNT_LO_OFS);
  wire logic wr_trim    = wr_acc && (paddr == `PTPCLK_TRIM_OFS);
  wire logic wr_goal_hi = wr_acc && (paddr == `PTPCLK_GOAL_HI_OFS);
  wire logic wr_goal_lo = wr_acc && (paddr == `PTPCLK_GOAL_LO_OFS);
  wire logic wr_cmd     = wr_acc && (paddr == `PTPCLK_CMD_OFS);
  wire logic wr_cfg     = wr_acc && (paddr == `PTPCLK_CFG_OFS);
  wire logic wr_stat    = wr_acc && (paddr == `PTPCLK_STAT_OFS);

  ptpclk_time_t counter_ff;
  ptpclk_word_t accum_ff;
  ptpclk_word_t rate_trim_ff;
  ptpclk_time_t frozen_ff;
  ptpclk_time_t goal_ff;
  ptpclk_word_t cnt_hold_ff;
  ptpclk_word_t goal_hold_ff;
  ptpclk_half_e cnt_half_ff;
  ptpclk_half_e goal_half_ff;
  ptpclk_time_t pin8_stamp_ff;
  ptpclk_time_t pin9_stamp_ff;
  logic [3:0]   cfg_ff;
  logic         hit_ff;
  logic [1:0]   p8_sync_ff;
  logic [1:0]   p9_sync_ff;
  logic         p8_prev_ff;
  logic         p9_prev_ff;
  ptpclk_word_t uuid_cap_ff [`PTPCLK_NPORT];

  // accumulator carry gates the counter step
  wire logic [32:0] accum_sum = {1'b0, accum_ff} + {1'b0, rate_trim_ff};
  wire logic        step      = accum_sum[32];

  // counter half pairing, a load needs both halves
  wire logic cnt_load = (wr_cnt_hi && cnt_half_ff == PTPCLK_HALF_LOWER)
                     || (wr_cnt_lo && cnt_half_ff == PTPCLK_HALF_UPPER);
  wire ptpclk_time_t cnt_new = wr_cnt_hi ? {pwdata, cnt_hold_ff} : {cnt_hold_ff, pwdata};
  wire logic goal_load = (wr_goal_hi && goal_half_ff == PTPCLK_HALF_LOWER)
                      || (wr_goal_lo && goal_half_ff == PTPCLK_HALF_UPPER);
  wire ptpclk_time_t goal_new = wr_goal_hi ? {pwdata, goal_hold_ff}
                                           : {goal_hold_ff, pwdata};

  // pin activation is a rising edge after synchronising
  wire logic p8_rise = p8_sync_ff[1] & ~p8_prev_ff;
  wire logic p9_rise = p9_sync_ff[1] & ~p9_prev_ff;
  wire logic match   = (counter_ff == goal_ff);

  // time counter and accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_ff <= `PTPCLK_ZERO64;
      accum_ff   <= `PTPCLK_ZERO32;
    end else begin
      accum_ff <= accum_sum[31:0];
      if (cnt_load) begin
        counter_ff <= cnt_new;
      end else if (step) begin
        counter_ff <= counter_ff + `PTPCLK_ONE64;
      end
    end
  end

  // half-write tracking for counter and target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_half_ff  <= PTPCLK_HALF_NONE;
      goal_half_ff <= PTPCLK_HALF_NONE;
      cnt_hold_ff  <= `PTPCLK_ZERO32;
      goal_hold_ff <= `PTPCLK_ZERO32;
    end else begin
      if (cnt_load) begin
        cnt_half_ff <= PTPCLK_HALF_NONE;
      end else if (wr_cnt_hi || wr_cnt_lo) begin
        cnt_half_ff <= wr_cnt_hi ? PTPCLK_HALF_UPPER : PTPCLK_HALF_LOWER;
        cnt_hold_ff <= pwdata;
      end
      if (goal_load) begin
        goal_half_ff <= PTPCLK_HALF_NONE;
      end else if (wr_goal_hi || wr_goal_lo) begin
        goal_half_ff <= wr_goal_hi ? PTPCLK_HALF_UPPER : PTPCLK_HALF_LOWER;
        goal_hold_ff <= pwdata;
      end
    end
  end

  // software registers: trim, target, config, snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_trim_ff <= `PTPCLK_ZERO32;
      goal_ff      <= `PTPCLK_ZERO64;
      frozen_ff    <= `PTPCLK_ZERO64;
      cfg_ff       <= 4'h0;
    end else begin
      if (wr_trim) begin
        rate_trim_ff <= pwdata;
      end
      if (goal_load) begin
        goal_ff <= goal_new;
      end
      if (wr_cfg) begin
        cfg_ff <= pwdata[3:0];
      end
      if (wr_cmd && pwdata[`PTPCLK_CMD_FREEZE_BIT]) begin
        frozen_ff <= counter_ff;
      end
    end
  end

  // sticky match flag, a new hit beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_ff <= 1'b0;
    end else if (match) begin
      hit_ff <= 1'b1;
    end else if (wr_stat && pwdata[`PTPCLK_STAT_HIT_BIT]) begin
      hit_ff <= 1'b0;
    end
  end

  // pin synchronisers and stamps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p8_sync_ff    <= 2'b00;
      p9_sync_ff    <= 2'b00;
      p8_prev_ff    <= 1'b0;
      p9_prev_ff    <= 1'b0;
      pin8_stamp_ff <= `PTPCLK_ZERO64;
      pin9_stamp_ff <= `PTPCLK_ZERO64;
    end else begin
      p8_sync_ff <= {p8_sync_ff[0], pin8_in};
      p9_sync_ff <= {p9_sync_ff[0], pin9_in};
      p8_prev_ff <= p8_sync_ff[1];
      p9_prev_ff <= p9_sync_ff[1];
      if (p8_rise) begin
        pin8_stamp_ff <= counter_ff;
      end
      if (p9_rise) begin
        pin9_stamp_ff <= counter_ff;
      end
    end
  end

  // per port transmit uuid capture, index 0 is the media-independent port
  genvar gi;
  generate
    for (gi = 0; gi < `PTPCLK_NPORT; gi = gi + 1) begin : g_port
      // master captures on sync, slave on delay_req; port 0 strobes are fabric-relative
      wire logic take = cfg_ff[gi] ? tx_sync_seen[gi] : tx_dreq_seen[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          uuid_cap_ff[gi] <= `PTPCLK_ZERO32;
        end else if (take) begin
          uuid_cap_ff[gi] <= tx_origin_id[gi*32 +: 32];
        end
      end
    end
  endgenerate

  // read mux
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = `PTPCLK_ZERO32;
    rd_hit = 1'b1;
    if (paddr == `PTPCLK_P1_UUID_OFS) begin
      rd_mux = uuid_cap_ff[1];
    end else if (paddr == `PTPCLK_P2_UUID_OFS) begin
      rd_mux = uuid_cap_ff[2];
    end else if (paddr == `PTPCLK_P0_UUID_OFS) begin
      rd_mux = uuid_cap_ff[0];
    end else if (paddr == `PTPCLK_G8_HI_OFS) begin
      rd_mux = pin8_stamp_ff[63:32];
    end else if (paddr == `PTPCLK_G8_LO_OFS) begin
      rd_mux = pin8_stamp_ff[31:0];
    end else if (paddr == `PTPCLK_G9_HI_OFS) begin
      rd_mux = pin9_stamp_ff[63:32];
    end else if (paddr == `PTPCLK_G9_LO_OFS) begin
      rd_mux = pin9_stamp_ff[31:0];
    end else if (paddr == `PTPCLK_CNT_HI_OFS) begin
      rd_mux = frozen_ff[63:32];
    end else if (paddr == `PTPCLK_CNT_LO_OFS) begin
      rd_mux = frozen_ff[31:0];
    end else if (paddr == `PTPCLK_TRIM_OFS) begin
      rd_mux = rate_trim_ff;
    end else if (paddr == `PTPCLK_GOAL_HI_OFS) begin
      rd_mux = goal_ff[63:32];
    end else if (paddr == `PTPCLK_GOAL_LO_OFS) begin
      rd_mux = goal_ff[31:0];
    end else if (paddr == `PTPCLK_CMD_OFS) begin
      rd_mux = `PTPCLK_ZERO32;
    end else if (paddr == `PTPCLK_CFG_OFS) begin
      rd_mux = {28'h0000000, cfg_ff};
    end else if (paddr == `PTPCLK_STAT_OFS) begin
      rd_mux = {31'h0, hit_ff};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // registered read data, zero-wait answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `PTPCLK_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~rd_hit;
  assign goal_hit_irq = hit_ff & cfg_ff[`PTPCLK_CFG_IE_BIT];

  // checks
  property p_step;
    @(posedge pclk) disable iff (!presetn)
      (!cnt_load && step) |=> counter_ff == $past(counter_ff) + `PTPCLK_ONE64;
  endproperty
  a_step: assert property (p_step) else $error("counter missed carry step");
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (!cnt_load && !step) |=> $stable(counter_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without carry");
  property p_accum;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> accum_ff == $past(accum_ff) + $past(rate_trim_ff);
  endproperty
  a_accum: assert property (p_accum) else $error("trim not accumulated");
  sequence s_half_one;
    (wr_cnt_hi || wr_cnt_lo) && cnt_half_ff == PTPCLK_HALF_NONE && !step;
  endsequence
  property p_pair;
    @(posedge pclk) disable iff (!presetn)
      s_half_one |=> $stable(counter_ff);
  endproperty
  a_pair: assert property (p_pair) else $error("counter loaded on one half");
  property p_load;
    @(posedge pclk) disable iff (!presetn)
      cnt_load |=> counter_ff == $past(cnt_new);
  endproperty
  a_load: assert property (p_load) else $error("counter load lost");
  property p_goal;
    @(posedge pclk) disable iff (!presetn)
      (wr_goal_hi && goal_half_ff == PTPCLK_HALF_NONE) |=> $stable(goal_ff);
  endproperty
  a_goal: assert property (p_goal) else $error("target changed on one half");
  property p_hit;
    @(posedge pclk) disable iff (!presetn)
      match |=> hit_ff;
  endproperty
  a_hit: assert property (p_hit) else $error("match flag not set");
  property p_pin8;
    @(posedge pclk) disable iff (!presetn)
      $rose(p8_sync_ff[1]) |=> pin8_stamp_ff == $past(counter_ff);
  endproperty
  a_pin8: assert property (p_pin8) else $error("pin 8 stamp wrong");
  property p_pin9;
    @(posedge pclk) disable iff (!presetn)
      $rose(p9_sync_ff[1]) |=> pin9_stamp_ff == $past(counter_ff);
  endproperty
  a_pin9: assert property (p_pin9) else $error("pin 9 stamp wrong");
  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
      (wr_cmd && pwdata[`PTPCLK_CMD_FREEZE_BIT]) |=> frozen_ff == $past(counter_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("snapshot not taken");
  property p_slave;
    @(posedge pclk) disable iff (!presetn)
      (!cfg_ff[1] && tx_dreq_seen[1]) |=> uuid_cap_ff[1] == $past(tx_origin_id[63:32]);
  endproperty
  a_slave: assert property (p_slave) else $error("slave capture wrong");
  property p_master;
    @(posedge pclk) disable iff (!presetn)
      (cfg_ff[0] && tx_sync_seen[0]) |=> uuid_cap_ff[0] == $past(tx_origin_id[31:0]);
  endproperty
  a_master: assert property (p_master) else $error("master capture wrong");
  property p_rd_frozen;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == `PTPCLK_CNT_LO_OFS)
        |=> prdata == $past(frozen_ff[31:0]);
  endproperty
  a_rd_frozen: assert property (p_rd_frozen) else $error("counter read not frozen copy");
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_stat && pwdata[`PTPCLK_STAT_HIT_BIT] && !match) |=> !hit_ff;
  endproperty
  a_clear: assert property (p_clear) else $error("match flag not cleared");
  property p_pin8_quiet;
    @(posedge pclk) disable iff (!presetn)
      !p8_rise |=> $stable(pin8_stamp_ff);
  endproperty
  a_pin8_quiet: assert property (p_pin8_quiet) else $error("pin 8 stamp moved");
  property p_pin9_quiet;
    @(posedge pclk) disable iff (!presetn)
      !p9_rise |=> $stable(pin9_stamp_ff);
  endproperty
  a_pin9_quiet: assert property (p_pin9_quiet) else $error("pin 9 stamp moved");
endmodule
`default_nettype wire

// >>> tb/ptpclk_mac_model.sv
// port mac model: one-cycle packet strobes carrying origin ids
`timescale 1ns/1ps
`default_nettype none
module ptpclk_mac_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [2:0]  sync_req,
  input  wire logic [2:0]  dreq_req,
  input  wire logic [31:0] id_req,
  output logic      [2:0]  tx_sync_seen,
  output logic      [2:0]  tx_dreq_seen,
  output logic      [95:0] tx_origin_id
);
  // id valid only with the strobe, inverted on every cycle without go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sync_seen <= 3'h0;
      tx_dreq_seen <= 3'h0;
      tx_origin_id <= 96'h0;
    end else begin
      tx_sync_seen <= go ? sync_req : 3'h0;
      tx_dreq_seen <= go ? dreq_req : 3'h0;
      tx_origin_id <= go ? {id_req + 32'h2, id_req + 32'h1, id_req} : ~tx_origin_id;
    end
  end
endmodule
`default_nettype wire

// >>> tb/ptpclk_top_tb.sv
// self-checking bench of the time clock unit
`timescale 1ns/1ps
`default_nettype none
`include "ptpclk_regs.svh"
module ptpclk_top_tb
  import ptpclk_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        pin8_in, pin9_in, go, goal_hit_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, id_req;
  logic [3:0]  pstrb;
  logic [2:0]  tx_sync_seen, tx_dreq_seen, sync_req, dreq_req;
  logic [95:0] tx_origin_id;
  int          error_cnt, checks_done, cyc;
  ptpclk_word_t snap_a;
  // rows: master selects, then expected capture of port 0, 1, 2
  logic [98:0] cap_row [2] = '{{3'b101, 32'h1111_0000, 32'h2222_0001, 32'h1111_0002},
                               {3'b010, 32'h2222_0000, 32'h1111_0001, 32'h2222_0002}};
  logic [11:0] port_ofs [3] = '{`PTPCLK_P0_UUID_OFS, `PTPCLK_P1_UUID_OFS, `PTPCLK_P2_UUID_OFS};

  ptpclk_top ptpclk_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin8_in(pin8_in), .pin9_in(pin9_in),
    .tx_sync_seen(tx_sync_seen), .tx_dreq_seen(tx_dreq_seen), .tx_origin_id(tx_origin_id),
    .goal_hit_irq(goal_hit_irq));
  ptpclk_mac_model ptpclk_mac_model_inst (.pclk(pclk), .presetn(presetn), .go(go),
    .sync_req(sync_req), .dreq_req(dreq_req), .id_req(id_req), .tx_sync_seen(tx_sync_seen),
    .tx_dreq_seen(tx_dreq_seen), .tx_origin_id(tx_origin_id));

  // compare tasks
  task automatic chk_word(input ptpclk_word_t got, input ptpclk_word_t exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // apb master: setup, then access held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask
  task automatic fire(input logic [2:0] s, input logic [2:0] q, input logic [31:0] id);
    @(posedge pclk);
    go <= 1'b1;
    sync_req <= s;
    dreq_req <= q;
    id_req <= id;
    @(posedge pclk);
    go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge pclk);
    #1;
    chk_bit(goal_hit_irq, exp);
    @(posedge pclk);
  endtask

  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      finish_test();
    end
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, pin8_in, pin9_in, go} = 7'h0;
    {paddr, pwdata, id_req, sync_req, dreq_req} = 82'h0;
    pstrb = 4'hf;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 3; p++) rchk(port_ofs[p], 32'h0);
    for (int a = 'h160; a <= 'h180; a += 4) rchk(a[11:0], 32'h0);
    apb(1'b0, 12'h1fc, 32'h0);
    chk_bit(err, 1'b1);
    wr(`PTPCLK_G8_HI_OFS, 32'hdead_beef);
    rchk(`PTPCLK_G8_HI_OFS, 32'h0);
    for (int r = 0; r < 2; r++) begin
      wr(`PTPCLK_CFG_OFS, {29'h0, cap_row[r][98:96]});
      fire(3'h7, 3'h0, 32'h1111_0000);
      fire(3'h0, 3'h7, 32'h2222_0000);
      for (int p = 0; p < 3; p++) rchk(port_ofs[p], cap_row[r][95-32*p -: 32]);
    end
    wr(`PTPCLK_CNT_HI_OFS, 32'h5);
    wr(`PTPCLK_CMD_OFS, 32'h1);
    rchk(`PTPCLK_CNT_HI_OFS, 32'h0);
    wr(`PTPCLK_CNT_LO_OFS, 32'h10);
    wr(`PTPCLK_CMD_OFS, 32'h1);
    rchk(`PTPCLK_CNT_HI_OFS, 32'h5);
    rchk(`PTPCLK_CNT_LO_OFS, 32'h10);
    wr(`PTPCLK_GOAL_HI_OFS, 32'h5);
    wr(`PTPCLK_GOAL_LO_OFS, 32'h20);
    wr(`PTPCLK_STAT_OFS, 32'h1);
    wr(`PTPCLK_CFG_OFS, 32'h8);
    irq_is(1'b0);
    wr(`PTPCLK_GOAL_LO_OFS, 32'h10);
    irq_is(1'b0);
    wr(`PTPCLK_GOAL_HI_OFS, 32'h5);
    irq_is(1'b1);
    rchk(`PTPCLK_GOAL_LO_OFS, 32'h10);
    wr(`PTPCLK_CFG_OFS, 32'h0);
    irq_is(1'b0);
    pin8_in <= 1'b1;
    repeat (6) @(posedge pclk);
    pin8_in <= 1'b0;
    wr(`PTPCLK_CNT_HI_OFS, 32'h6);
    wr(`PTPCLK_CNT_LO_OFS, 32'h30);
    pin9_in <= 1'b1;
    repeat (6) @(posedge pclk);
    pin9_in <= 1'b0;
    rchk(`PTPCLK_G8_HI_OFS, 32'h5);
    rchk(`PTPCLK_G8_LO_OFS, 32'h10);
    rchk(`PTPCLK_G9_HI_OFS, 32'h6);
    rchk(`PTPCLK_G9_LO_OFS, 32'h30);
    wr(`PTPCLK_TRIM_OFS, 32'h8000_0000);
    rchk(`PTPCLK_TRIM_OFS, 32'h8000_0000);
    wr(`PTPCLK_CMD_OFS, 32'h1);
    apb(1'b0, `PTPCLK_CNT_LO_OFS, 32'h0);
    snap_a = rd;
    rchk(`PTPCLK_CNT_LO_OFS, snap_a);
    @(posedge pclk);
    wr(`PTPCLK_CMD_OFS, 32'h1);
    rchk(`PTPCLK_CNT_LO_OFS, snap_a + 32'h5);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk_bit(goal_hit_irq, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    rchk(`PTPCLK_TRIM_OFS, 32'h0);
    rchk(`PTPCLK_CNT_LO_OFS, 32'h0);
    rchk(`PTPCLK_G9_HI_OFS, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
